// >>> design/timer_clock_regs.vh
`ifndef TIMER_CLOCK_REGS_VH
`define TIMER_CLOCK_REGS_VH
// Register indices on the plain port
`define ADDR_CONTROL      4'h0
`define ADDR_COUNT_LOW    4'h1
`define ADDR_COUNT_HIGH   4'h2
`define ADDR_STATUS       4'h3
`define ADDR_MASK         4'h4
`define ADDR_SLEEP        4'h5
// Control field positions
`define CLK_SEL_HI        7
`define CLK_SEL_LO        6
`define PRE_HI            5
`define PRE_LO            4
`define OSC_EN_BIT        3
`define SYNC_BYP_BIT      2
`define RUN_BIT           0
`define CONTROL_MASK      8'hFD
`define CONTROL_RESET     8'h00
// Clock select codes
`define SEL_INSTR         2'h0
`define SEL_SYSTEM        2'h1
`define SEL_EXT           2'h2
// Status bits
`define ST_ROLLOVER       0
`define ST_WAKE           1
// Instruction clock is system clock over four
`define INSTR_DIV         2'h3
`endif

// >>> design/count_prescaler.v
`timescale 1ns/1ps
// Divides a one-cycle tick by 1, 2, 4 or 8
module count_prescaler (
   input  wire       clk,
   input  wire       reset,
   input  wire       clear,
   input  wire [1:0] ratio_sel,
   input  wire       tick_in,
   output wire       tick_out
);
   reg  [2:0] div_reg;
   wire [2:0] top;
   assign top = (3'h1 << ratio_sel) - 3'h1;
   assign tick_out = tick_in & (div_reg == top);
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg <= 3'h0;
      end else if (clear) begin
         div_reg <= 3'h0;
      end else if (tick_in) begin
         div_reg <= (div_reg == top) ? 3'h0 : div_reg + 3'h1;
      end
   end
endmodule // count_prescaler

// >>> design/timer_clock_control.v
`timescale 1ns/1ps
`include "timer_clock_regs.vh"
// ===============================================
module timer_clock_control (
   input  wire       clk,
   input  wire       reset,
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   input  wire       external_count_pin,
   input  wire       osc_clock_in,
   input  wire       sleep_mode,
   output reg        secondary_osc_enable,
   output reg        gate_toggle_clear,
   output reg        wake_request,
   output reg        irq
);
   // ===============================================
   // State and next-state signals
   reg  [7:0]  ctrl_reg;
   reg  [15:0] count_reg;
   reg  [1:0]  status_reg;
   reg  [1:0]  mask_reg;
   reg  [1:0]  pin_sync_reg;
   reg  [1:0]  osc_sync_reg;
   reg         ext_prev_reg;
   reg         sync_edge_reg;
   reg  [1:0]  instr_div_reg;
   reg  [15:0] count_next;
   reg  [1:0]  status_next;
   reg  [7:0]  rdata_next;
   wire [1:0]  clk_sel;
   wire        ext_level;
   wire        raw_edge;
   wire        ext_edge;
   wire        raw_tick;
   wire        pre_tick;
   wire        sel_ext;
   wire        async_mode;
   wire        may_count;
   wire        rollover;
   wire        wr_low;
   wire        wr_high;
   wire        wr_ctrl;
   wire        wr_status;
   wire        wr_mask;

   // ===============================================
   // Clock source selection
   assign clk_sel = ctrl_reg[`CLK_SEL_HI:`CLK_SEL_LO];
   assign sel_ext = (clk_sel == `SEL_EXT);
   // Oscillator path when enabled, else the pin
   assign ext_level = ctrl_reg[`OSC_EN_BIT] ? osc_sync_reg[1]
                                            : pin_sync_reg[1];
   assign raw_edge = ext_level & ~ext_prev_reg;
   // sync choice
   // Bypass counts the edge straight from the input flops; the
   // synchronised path re-times it through one more flop first.
   assign ext_edge = ctrl_reg[`SYNC_BYP_BIT] ? raw_edge : sync_edge_reg;
   assign async_mode = sel_ext & ctrl_reg[`SYNC_BYP_BIT];
   assign may_count = ctrl_reg[`RUN_BIT] & (~sleep_mode | async_mode);
   assign raw_tick = (clk_sel == `SEL_SYSTEM) ? 1'b1 :
                     sel_ext ? ext_edge :
                     (clk_sel == `SEL_INSTR) ? (instr_div_reg == `INSTR_DIV)
                                             : 1'b0;

   // ===============================================
   // Prescaler
   // Run low clears the ratio count so a restart begins a full period
   // ratio divide
   count_prescaler u_pre (
      .clk       (clk),
      .reset     (reset),
      .clear     (~ctrl_reg[`RUN_BIT]),
      .ratio_sel (ctrl_reg[`PRE_HI:`PRE_LO]),
      .tick_in   (raw_tick & may_count),
      .tick_out  (pre_tick)
   );

   assign wr_low   = wr & (addr == `ADDR_COUNT_LOW);
   assign wr_high  = wr & (addr == `ADDR_COUNT_HIGH);
   // A count write in the same cycle wins, so it raises no flag
   // wrap detect
   assign rollover = pre_tick & (count_reg == 16'hFFFF) & ~wr_low & ~wr_high;

   // ===============================================
   // Input synchronisers and dividers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_sync_reg  <= 2'h0;
         osc_sync_reg  <= 2'h0;
         ext_prev_reg  <= 1'b0;
         sync_edge_reg <= 1'b0;
         instr_div_reg <= 2'h0;
      end else begin
         pin_sync_reg  <= {pin_sync_reg[0], external_count_pin};
         osc_sync_reg  <= {osc_sync_reg[0], osc_clock_in};
         ext_prev_reg  <= ext_level;
         sync_edge_reg <= raw_edge & ~ctrl_reg[`SYNC_BYP_BIT];
         // Free-running, so the instruction tick phase ignores the run bit
         instr_div_reg <= instr_div_reg + 2'h1;
      end
   end

   // ===============================================
   // Write decodes
   assign wr_ctrl   = wr & (addr == `ADDR_CONTROL);
   assign wr_status = wr & (addr == `ADDR_STATUS);
   assign wr_mask   = wr & (addr == `ADDR_MASK);

   // ===============================================
   // Next-state logic
   // count and wrap
   // Software write to a count byte beats a tick in the same cycle
   always @* begin
      count_next = count_reg;
      if (wr_low) begin
         count_next[7:0] = wdata;
      end else if (wr_high) begin
         count_next[15:8] = wdata;
      end else if (pre_tick) begin
         count_next = count_reg + 16'h0001;
      end
   end

   // sticky flag, set wins over clear
   // Flags are write-one-to-clear
   always @* begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & ~wdata[1:0];
      end
      if (rollover) begin
         status_next[`ST_ROLLOVER] = 1'b1;
      end
      if (rollover && sleep_mode) begin
         status_next[`ST_WAKE] = 1'b1;
      end
   end

   // Read data stands only in the cycle after the strobe
   always @* begin
      rdata_next = 8'h00;
      if (rd) begin
         case (addr)
            `ADDR_CONTROL:    rdata_next = ctrl_reg;
            `ADDR_COUNT_LOW:  rdata_next = count_reg[7:0];
            `ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
            `ADDR_STATUS:     rdata_next = {6'h00, status_reg};
            `ADDR_MASK:       rdata_next = {6'h00, mask_reg};
            `ADDR_SLEEP:      rdata_next = {7'h00, sleep_mode};
            default:          rdata_next = 8'h00;
         endcase
      end
   end

   // ===============================================
   // Control and mask registers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= `CONTROL_RESET;
         mask_reg <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= wdata & `CONTROL_MASK;
         end
         if (wr_mask) begin
            mask_reg <= wdata[1:0];
         end
      end
   end

   // ===============================================
   // Counter and status
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count_reg  <= 16'h0000;
         status_reg <= 2'h0;
      end else begin
         count_reg  <= count_next;
         status_reg <= status_next;
      end
   end

   // ===============================================
   // Output registers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata                <= 8'h00;
         secondary_osc_enable <= 1'b0;
         gate_toggle_clear    <= 1'b1;
         wake_request         <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         rdata                <= rdata_next;
         // oscillator enable
         // Not gated by sleep or sync bit, so it runs on in sleep
         secondary_osc_enable <= ctrl_reg[`OSC_EN_BIT];
         gate_toggle_clear    <= ~ctrl_reg[`RUN_BIT];
         wake_request         <= status_reg[`ST_WAKE];
         irq                  <= |(status_reg & mask_reg);
      end
   end
endmodule // timer_clock_control

// >>> tb/ext_clock_src.sv
`timescale 1ns/1ps
// ==========
// Pin or crystal source, idle low so no stray edge is counted
module ext_clock_src (
   output logic pin,
   output logic osc
);
   initial {pin, osc} = 2'b00;
   task automatic burst(input int n, input bit use_osc);
      // Changes fall between clock edges; a call lasts whole periods
      repeat (n) begin
         #11 if (use_osc) osc = 1'b1; else pin = 1'b1;
         #10 {pin, osc} = 2'b00;
         #11;
      end
   endtask
endmodule // ext_clock_src

// >>> tb/timer_clock_control_sva.sv
`timescale 1ns/1ps
// ==========
// Port checks
module timer_clock_control_sva (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       sleep_mode,
   input wire logic       secondary_osc_enable,
   input wire logic       gate_toggle_clear,
   input wire logic       wake_request,
   input wire logic       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire wc = wr && addr == 4'h0;
   wire wm = wr && addr == 4'h4;
   a_osc_follow: assert property (
      wc ##1 !wc |=> secondary_osc_enable == $past(wdata[3], 2))
      else $error("osc enable not following control");
   a_gate_clear: assert property (
      wc ##1 !wc |=> gate_toggle_clear == !$past(wdata[0], 2))
      else $error("gate toggle clear not following run");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (
      rd && addr > 4'h5 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (
      wc ##1 rd && addr == 4'h0 |=> rdata == ($past(wdata, 2) & 8'hFD))
      else $error("control readback wrong");
   a_reset_values: assert property ($fell(reset) |-> gate_toggle_clear
      && !irq && !wake_request && !secondary_osc_enable)
      else $error("outputs wrong after reset");
   a_mask_quiet: assert property (
      wm && wdata == 8'h00 ##1 !wm [*2] |=> !irq)
      else $error("masked interrupt still high");
   a_wake_sleep: assert property ($rose(wake_request)
      |-> $past(sleep_mode, 2) || $past(sleep_mode, 3))
      else $error("wake while awake");
endmodule // timer_clock_control_sva

bind timer_clock_control timer_clock_control_sva i_sva (.clk(clk),
   .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .sleep_mode(sleep_mode), .irq(irq),
   .secondary_osc_enable(secondary_osc_enable),
   .gate_toggle_clear(gate_toggle_clear), .wake_request(wake_request));

// >>> tb/tb_timer_clock_control.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench
module tb_timer_clock_control;
   logic clk = 0, reset = 1, wr = 0, rd = 0, sleep_mode = 0, rd_d = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, s, q[$];
   logic [15:0] e;
   wire [7:0] rdata;
   wire pin, osc, osc_en, gclr, wake, irq;
   int failures = 0, n_compared = 0, i;
   initial forever #2 clk = ~clk;
   ext_clock_src i_src (.pin(pin), .osc(osc));
   timer_clock_control i_dut (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .external_count_pin(pin), .osc_clock_in(osc),
      .sleep_mode(sleep_mode), .secondary_osc_enable(osc_en),
      .gate_toggle_clear(gclr), .wake_request(wake), .irq(irq));
   task automatic check(input string nm, logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Strobes stay up between accesses so no edge sees two assignments
   task automatic acc(input logic [3:0] a, logic [7:0] d, bit r);
      addr <= a;
      wdata <= d;
      wr <= !r;
      rd <= r;
      if (r) q.push_back(d);
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // Re-align to a clock edge before the next register access
   task automatic pulses(input int n, input bit use_osc);
      i_src.burst(n, use_osc);
      @(posedge clk);
   endtask
   task automatic setup(input logic [15:0] c, logic [7:0] ctl);
      acc(4'h0, 8'h00, 0);
      acc(4'h1, c[7:0], 0);
      acc(4'h2, c[15:8], 0);
      acc(4'h0, ctl, 0);
   endtask
   // Stopping first keeps the count still while both bytes are read
   task automatic rdcnt(input logic [15:0] c);
      acc(4'h0, 8'h00, 0);
      idle(4);
      acc(4'h1, c[7:0], 1);
      acc(4'h2, c[15:8], 1);
      idle(2);
   endtask
   // ==========
   // Read slot watcher
   always @(posedge clk) begin
      if (rd_d) check("rdata", rdata, q.pop_front());
      rd_d <= rd;
   end
   initial begin
      s = $urandom(17108);
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      acc(4'h0, 8'h00, 1);
      acc(4'h0, 8'hFF, 0);
      acc(4'h0, 8'hFD, 1);
      acc(4'h9, 8'h5A, 0);
      acc(4'h9, 8'h00, 1);
      idle(2);
      check("osc_en", {7'h0, osc_en}, 8'h01);
      check("gclr", {7'h0, gclr}, 8'h00);
      for (i = 0; i < 4; i++) begin
         s = $urandom;
         e = {8'h00, s} + (16'h0040 >> i);
         setup({8'h00, s}, {2'b01, i[1:0], 4'h1});
         idle(63);
         rdcnt(e);
      end
      setup(16'h0000, 8'h01);
      idle(63);
      rdcnt(16'h0010);
      acc(4'h4, 8'h01, 0);
      setup(16'hFFFE, 8'h41);
      idle(1);
      for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
      check("irq", {7'h0, irq}, 8'h01);
      if (irq !== 1'b1) conclude();
      acc(4'h4, 8'h00, 0);
      idle(3);
      check("irq", {7'h0, irq}, 8'h00);
      acc(4'h0, 8'h00, 0);
      acc(4'h3, 8'h01, 1);
      acc(4'h3, 8'h01, 0);
      acc(4'h3, 8'h00, 1);
      setup(16'h0000, 8'h81);
      idle(1);
      pulses(5, 0);
      acc(4'h0, 8'h89, 0);
      idle(1);
      pulses(7, 1);
      acc(4'h0, 8'h85, 0);
      idle(1);
      pulses(3, 0);
      idle(8);
      rdcnt(16'h000F);
      sleep_mode <= 1'b1;
      setup(16'hFFFF, 8'h89);
      idle(1);
      pulses(3, 1);
      check("osc_en", {7'h0, osc_en}, 8'h01);
      acc(4'h0, 8'h8D, 0);
      idle(1);
      pulses(1, 1);
      for (i = 0; i < 40 && wake !== 1'b1; i++) @(posedge clk);
      check("wake", {7'h0, wake}, 8'h01);
      if (wake !== 1'b1) conclude();
      check("osc_en", {7'h0, osc_en}, 8'h01);
      rdcnt(16'h0000);
      acc(4'h3, 8'h03, 1);
      idle(2);
      conclude();
   end
endmodule // tb_timer_clock_control
